//--- hdl/sweep_output_control.sv
// Sweep output controller: APB registers, sweep sequencer, waveform
// selection, square and status pins, standby and abort handling.
// Assumes APB master on pclk, host serial port on its own clock.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sweep_output_control_map.svh"

module sweep_output_control (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  input  wire logic                sclk,
  input  wire logic                frame_select,
  input  wire logic                serial_data_in,
  input  wire logic                sweep_abort,
  input  wire logic                low_power,
  output var  logic [`DAC_W-1:0]   analog_current_outputs,
  output var  logic                dac_enable,
  output var  logic                power_down,
  output var  logic                square_wave_output,
  output var  logic                sweep_status_output
);

  // ************************************************************
  // Serial port on the host clock
  // ************************************************************
  sweep_output_control_pkg::serial_word_t ser_word;
  logic                                   ser_toggle;

  serial_word_rx u_rx (
    .sclk           (sclk),
    .presetn        (presetn),
    .frame_select   (frame_select),
    .serial_data_in (serial_data_in),
    .word_r         (ser_word),
    .word_toggle_r  (ser_toggle)
  );

  // ************************************************************
  // Pin and crossing synchronisers
  // ************************************************************
  // Bit 2 serial toggle, bit 1 abort pin, bit 0 standby pin
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [2:0] prev_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      prev_r <= 3'h0;
    end else begin
      meta_r <= {ser_toggle, sweep_abort, low_power};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  wire logic standby;
  wire logic abort_rise;
  wire logic ser_evt;

  assign standby    = sync_r[0];
  assign abort_rise = sync_r[1] & ~prev_r[1];
  // Word is stable for a full frame after its toggle, so reading it
  // behind the synchronised toggle needs no further staging
  assign ser_evt    = sync_r[2] ^ prev_r[2];

  // ************************************************************
  // Register file
  // ************************************************************
  localparam logic [31:0] REG_MASK [0:4] = '{
    `MASK_CONTROL, `MASK_START_FREQ, `MASK_DELTA_FREQ,
    `MASK_NUM_INCR, `MASK_INTERVAL
  };
  localparam logic [31:0] REG_RST [0:4] = '{
    `RST_CONTROL, `RST_START_FREQ, `RST_DELTA_FREQ,
    `RST_NUM_INCR, `RST_INTERVAL
  };

  logic [31:0] reg_r [0:4];

  wire logic [2:0] apb_idx;
  wire logic       apb_hit;
  wire logic       apb_setup;
  wire logic       apb_access;
  wire logic       apb_we;
  wire logic [2:0] ser_idx;
  wire logic [1:0] ser_lane;
  wire logic [7:0] ser_data;
  wire logic       ser_we;

  assign apb_idx    = paddr[4:2];
  assign apb_hit    = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0)
                      && (apb_idx < `REG_COUNT);
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable & pready;
  assign apb_we     = apb_access & pwrite & apb_hit & (apb_idx < `REG_WRITABLE);

  // Control nibble low two bits pick the byte lane of the target word
  assign ser_lane = ser_word[13:12];
  assign ser_idx  = ser_word[10:8];
  assign ser_data = ser_word[7:0];
  assign ser_we   = ser_evt & (ser_idx < `REG_WRITABLE) & (ser_word[11] == 1'b0);

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_reg
      wire logic        apb_sel;
      wire logic        ser_sel;
      wire logic [31:0] lane_word;

      assign apb_sel   = apb_we && (apb_idx == 3'(gi));
      assign ser_sel   = ser_we && (ser_idx == 3'(gi));
      assign lane_word = (reg_r[gi] & ~(32'h0000_00ff << {ser_lane, 3'h0}))
                         | ({24'h00_0000, ser_data} << {ser_lane, 3'h0});

      // Bus write wins over a serial write landing in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          reg_r[gi] <= REG_RST[gi];
        end else if (apb_sel) begin
          reg_r[gi] <= pwdata & REG_MASK[gi];
        end else if (ser_sel) begin
          reg_r[gi] <= lane_word & REG_MASK[gi];
        end
      end
    end
  endgenerate

  // Start and abort are command bits that are never stored
  wire logic cmd_start;
  wire logic cmd_abort;

  assign cmd_start = (apb_we && apb_idx == 3'h0 && pwdata[`BIT_START])
                     || (ser_we && ser_idx == 3'h0 && ser_lane == 2'h0
                         && ser_data[`BIT_START]);
  assign cmd_abort = (apb_we && apb_idx == 3'h0 && pwdata[`BIT_ABORT])
                     || (ser_we && ser_idx == 3'h0 && ser_lane == 2'h0
                         && ser_data[`BIT_ABORT]);

  wire logic                sync_en;
  wire logic                sync_sel;
  wire logic                square_en;
  wire logic                sine_sel;
  wire logic                dac_en;
  wire logic [`PHASE_W-1:0] start_freq;
  wire logic [`PHASE_W-1:0] delta_freq;
  wire logic [11:0]         num_incr;
  wire logic [15:0]         interval;

  assign sync_en    = reg_r[0][`BIT_SYNC_EN];
  assign sync_sel   = reg_r[0][`BIT_SYNC_SEL];
  assign square_en  = reg_r[0][`BIT_SQUARE_EN];
  assign sine_sel   = reg_r[0][`BIT_SINE_SEL];
  assign dac_en     = reg_r[0][`BIT_DAC_EN];
  assign start_freq = reg_r[1][`PHASE_W-1:0];
  assign delta_freq = reg_r[2][`PHASE_W-1:0];
  assign num_incr   = reg_r[3][11:0];
  assign interval   = reg_r[4][15:0];

  // ************************************************************
  // Sweep sequencer
  // ************************************************************
  sweep_output_control_pkg::sweep_state_t state_r;
  sweep_output_control_pkg::sweep_state_t state_nxt;

  logic [`PHASE_W-1:0] freq_r;
  logic [`PHASE_W-1:0] phase_r;
  logic [11:0]         incr_cnt_r;
  logic [15:0]         intv_cnt_r;
  logic [2:0]          pulse_cnt_r;

  wire logic abort_evt;
  wire logic intv_end;
  wire logic last_step;
  wire logic step;

  assign abort_evt = abort_rise | cmd_abort;
  // Intervals below two cycles behave as two
  assign intv_end  = (intv_cnt_r + 16'h0001 >= interval) && (intv_cnt_r != 16'h0000);
  assign last_step = (incr_cnt_r == num_incr);
  assign step      = (state_r == sweep_output_control_pkg::SWEEP_RUN) & intv_end
                     & ~last_step & ~standby;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      sweep_output_control_pkg::SWEEP_IDLE, sweep_output_control_pkg::SWEEP_DONE: begin
        if (cmd_start) begin
          state_nxt = sweep_output_control_pkg::SWEEP_RUN;
        end
      end
      sweep_output_control_pkg::SWEEP_RUN: begin
        if (intv_end && last_step) begin
          state_nxt = sweep_output_control_pkg::SWEEP_DONE;
        end
      end
      default: begin
        state_nxt = sweep_output_control_pkg::SWEEP_IDLE;
      end
    endcase
  end

  // Abort acts even in standby so the recovery reset is never missed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= sweep_output_control_pkg::SWEEP_IDLE;
    end else if (abort_evt) begin
      state_r <= sweep_output_control_pkg::SWEEP_IDLE;
    end else if (!standby) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_r     <= 24'h00_0000;
      incr_cnt_r <= 12'h000;
      intv_cnt_r <= 16'h0000;
    end else if (abort_evt) begin
      incr_cnt_r <= 12'h000;
      intv_cnt_r <= 16'h0000;
    end else if (!standby) begin
      if (cmd_start && state_r != sweep_output_control_pkg::SWEEP_RUN) begin
        freq_r     <= start_freq;
        incr_cnt_r <= 12'h000;
        intv_cnt_r <= 16'h0000;
      end else if (state_r == sweep_output_control_pkg::SWEEP_RUN) begin
        intv_cnt_r <= intv_end ? 16'h0000 : intv_cnt_r + 16'h0001;
        if (step) begin
          freq_r     <= freq_r + delta_freq;
          incr_cnt_r <= incr_cnt_r + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 24'h00_0000;
    end else if (abort_evt) begin
      phase_r <= 24'h00_0000;
    end else if (standby) begin
      phase_r <= phase_r;
    end else if (state_r == sweep_output_control_pkg::SWEEP_IDLE) begin
      phase_r <= 24'h00_0000;
    end else begin
      phase_r <= phase_r + freq_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_r <= 3'h0;
    end else if (abort_evt) begin
      pulse_cnt_r <= 3'h0;
    end else if (standby) begin
      pulse_cnt_r <= pulse_cnt_r;
    end else if (step) begin
      pulse_cnt_r <= `SYNC_PULSE_CYCLES;
    end else if (pulse_cnt_r != 3'h0) begin
      pulse_cnt_r <= pulse_cnt_r - 3'h1;
    end
  end

  // ************************************************************
  // Waveform selection
  // ************************************************************
  // Quarter-wave table; coarse 7-bit phase keeps it small at some cost in purity
  localparam logic [8:0] QUARTER_SINE [0:31] = '{
    9'h00d, 9'h026, 9'h03f, 9'h057, 9'h070, 9'h088, 9'h0a0, 9'h0b8,
    9'h0cf, 9'h0e6, 9'h0fc, 9'h111, 9'h126, 9'h13a, 9'h14e, 9'h160,
    9'h172, 9'h183, 9'h193, 9'h1a2, 9'h1b0, 9'h1bd, 9'h1c8, 9'h1d3,
    9'h1dd, 9'h1e5, 9'h1ed, 9'h1f3, 9'h1f7, 9'h1fb, 9'h1fe, 9'h1ff
  };

  wire logic [4:0]        quad_idx;
  wire logic [8:0]        sine_mag;
  wire logic [`DAC_W-1:0] sine_code;
  wire logic [`DAC_W-1:0] tri_code;
  wire logic [`DAC_W-1:0] wave_code;
  wire logic [`DAC_W-1:0] dac_nxt;

  // Sine lookup table path
  assign quad_idx  = phase_r[22] ? ~phase_r[21:17] : phase_r[21:17];
  assign sine_mag  = QUARTER_SINE[quad_idx];
  assign sine_code = phase_r[23] ? (`MIDSCALE - {1'b0, sine_mag})
                                 : (`MIDSCALE + {1'b0, sine_mag});
  assign tri_code  = phase_r[23] ? ~phase_r[22:13] : phase_r[22:13];
  assign wave_code = sine_sel ? sine_code : tri_code;
  assign dac_nxt   = (state_r == sweep_output_control_pkg::SWEEP_IDLE) ? `MIDSCALE
                     : wave_code;

  // ************************************************************
  // Output pins
  // ************************************************************
  wire logic               status_nxt;
  wire logic [`DAC_W-1:0] out_code;

  // Square pin follows the code actually loaded, abort midscale included
  assign out_code   = abort_evt ? `MIDSCALE : dac_nxt;
  assign status_nxt = sync_en & (sync_sel ? (state_r == sweep_output_control_pkg::SWEEP_DONE)
                                          : (pulse_cnt_r != 3'h0));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_current_outputs <= `MIDSCALE;
      square_wave_output     <= 1'b0;
      sweep_status_output    <= 1'b0;
      dac_enable             <= 1'b0;
      power_down             <= 1'b0;
    end else begin
      if (abort_evt || !standby) begin
        analog_current_outputs <= out_code;
        square_wave_output     <= square_en & ~out_code[`DAC_W-1];
      end
      if (!standby) begin
        sweep_status_output <= status_nxt;
      end
      dac_enable <= dac_en & ~standby;
      power_down <= standby;
    end
  end

  // ************************************************************
  // APB slave answer
  // ************************************************************
  wire logic [31:0] status_word;
  wire logic [31:0] read_word;

  assign status_word = {16'h0000, standby,
                        (state_r == sweep_output_control_pkg::SWEEP_DONE),
                        (state_r == sweep_output_control_pkg::SWEEP_RUN),
                        1'b0, incr_cnt_r};
  assign read_word   = !apb_hit ? 32'h0000_0000
                     : (apb_idx == 3'h5) ? status_word
                     : reg_r[apb_idx];

  // One wait-free access cycle: answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~apb_hit;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : read_word;
      end
    end
  end

endmodule
`default_nettype wire

//--- hdl/sweep_output_control_map.svh
// Constants of the sweep output controller: register offsets, field
// positions, reset values and timing counts.
// Assumes inclusion by bare name from the design and bench files.
`ifndef SWEEP_OUTPUT_CONTROL_MAP_SVH
`define SWEEP_OUTPUT_CONTROL_MAP_SVH

// ************************************************************
// Register byte offsets on the APB
// ************************************************************
`define OFS_CONTROL        12'h000
`define OFS_START_FREQ     12'h004
`define OFS_DELTA_FREQ     12'h008
`define OFS_NUM_INCR       12'h00c
`define OFS_INTERVAL       12'h010
`define OFS_STATUS         12'h014
`define REG_COUNT          3'h6
`define REG_WRITABLE       3'h5

// ************************************************************
// Writable field masks and reset values
// ************************************************************
`define MASK_CONTROL       32'h0000_070c
`define MASK_START_FREQ    32'h00ff_ffff
`define MASK_DELTA_FREQ    32'h00ff_ffff
`define MASK_NUM_INCR      32'h0000_0fff
`define MASK_INTERVAL      32'h0000_ffff
`define RST_CONTROL        32'h0000_0000
`define RST_START_FREQ     32'h0000_0000
`define RST_DELTA_FREQ     32'h0000_0000
`define RST_NUM_INCR       32'h0000_0000
`define RST_INTERVAL       32'h0000_0002

// ************************************************************
// Control bit positions
// ************************************************************
`define BIT_START          0
`define BIT_ABORT          1
`define BIT_SYNC_EN        2
`define BIT_SYNC_SEL       3
`define BIT_SQUARE_EN      8
`define BIT_SINE_SEL       9
`define BIT_DAC_EN         10

// ************************************************************
// Datapath widths, levels and timing
// ************************************************************
`define PHASE_W            24
`define DAC_W              10
`define MIDSCALE           10'h200
`define SYNC_PULSE_CYCLES  3'h4
`define SERIAL_BITS        5'h10

`endif

//--- hdl/sweep_output_control_pkg.sv
// Types shared by the sweep output controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package sweep_output_control_pkg;

  typedef enum logic [1:0] {
    SWEEP_IDLE,
    SWEEP_RUN,
    SWEEP_DONE
  } sweep_state_t;

  typedef logic [15:0] serial_word_t;

endpackage

//--- hdl/serial_word_rx.sv
// Serial write port: shifts 16 bits on the serial clock's falling edge.
// Assumes frame_select low for a whole word; the word is held stable
// until the next complete frame, the toggle marks each new word.
`timescale 1ns/1ps
`default_nettype none
`include "sweep_output_control_map.svh"

module serial_word_rx (
  input  wire logic                                 sclk,
  input  wire logic                                 presetn,
  input  wire logic                                 frame_select,
  input  wire logic                                 serial_data_in,
  output var  sweep_output_control_pkg::serial_word_t word_r,
  output var  logic                                 word_toggle_r
);

  logic [14:0] shift_r;
  logic [4:0]  count_r;
  wire  logic  last_bit;
  wire  logic  frame_clear;

  assign last_bit    = (count_r == (`SERIAL_BITS - 5'h1));
  // Frame end clears the count without any clock edge, so a stopped
  // or idling serial clock cannot leave a half word behind
  assign frame_clear = frame_select | ~presetn;

  always_ff @(negedge sclk or posedge frame_clear) begin
    if (frame_clear) begin
      count_r <= 5'h00;
      shift_r <= 15'h0000;
    end else if (count_r != `SERIAL_BITS) begin
      shift_r <= {shift_r[13:0], serial_data_in};
      count_r <= count_r + 5'h01;
    end
  end

  always_ff @(negedge sclk or negedge presetn) begin
    if (!presetn) begin
      word_r        <= 16'h0000;
      word_toggle_r <= 1'b0;
    end else if (!frame_select && last_bit) begin
      word_r        <= {shift_r, serial_data_in};
      word_toggle_r <= ~word_toggle_r;
    end
  end

endmodule
`default_nettype wire

//--- bench/sweep_output_control_assertions.sv
// Checker: APB handshake, abort, standby and output pin relations.
// Assumes binding to the controller top; all properties on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "sweep_output_control_map.svh"
module sweep_output_control_assertions (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [11:0]       paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              sweep_abort,
  input wire logic              low_power,
  input wire logic [`DAC_W-1:0] analog_current_outputs,
  input wire logic              dac_enable,
  input wire logic              power_down,
  input wire logic              square_wave_output,
  input wire logic              sweep_status_output
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing");
  property p_err; psel && !penable && paddr > 12'h014 |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_abort; $rose(sweep_abort) |-> ##[1:6] analog_current_outputs == `MIDSCALE; endproperty
  a_abort: assert property (p_abort) else $error("abort not midscale");
  property p_pd_on; $rose(low_power) |-> ##[1:4] power_down; endproperty
  a_pd_on: assert property (p_pd_on) else $error("standby not entered");
  property p_dac_off; power_down && $past(power_down) |-> !dac_enable; endproperty
  a_dac_off: assert property (p_dac_off) else $error("converter on in standby");
  property p_freeze;
    power_down && $past(power_down) |->
      $stable(analog_current_outputs) && $stable(sweep_status_output);
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved in standby");
  property p_pd_off; $fell(low_power) |-> ##[1:4] !power_down; endproperty
  a_pd_off: assert property (p_pd_off) else $error("standby not left");
  property p_square; square_wave_output |-> !analog_current_outputs[`DAC_W-1]; endproperty
  a_square: assert property (p_square) else $error("square not inverted msb");
  property p_pulse; $rose(sweep_status_output) |-> sweep_status_output[*4]; endproperty
  a_pulse: assert property (p_pulse) else $error("status pulse short");
endmodule
bind sweep_output_control sweep_output_control_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sweep_abort(sweep_abort), .low_power(low_power),
  .analog_current_outputs(analog_current_outputs), .dac_enable(dac_enable),
  .power_down(power_down), .square_wave_output(square_wave_output),
  .sweep_status_output(sweep_status_output));
`default_nettype wire

//--- bench/serial_host_model.sv
// Host serial port model: frames words MSB first on its own clock.
// Assumes the bench calls send; clock period 15 ns.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  output var logic sclk,
  output var logic frame_select,
  output var logic serial_data_in
);
  logic idle_lvl = 1'b1;
  logic free_run = 1'b0;
  logic busy     = 1'b0;
  initial begin
    sclk = 1'b1;
    frame_select = 1'b1;
    serial_data_in = 1'b0;
  end
  // Runs free, or rests high or low between frames
  always begin
    #7.5;
    if (busy || free_run) begin
      sclk = ~sclk;
    end else begin
      sclk = idle_lvl;
    end
  end
  // Data moves on rising edge so it is steady at the falling one
  task automatic send(input logic [15:0] w, input int n, input int mode);
    begin
      idle_lvl = (mode == 1);
      free_run = (mode == 2);
      #15;
      busy = 1'b1;
      @(posedge sclk);
      frame_select = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
        serial_data_in = w[i];
        @(negedge sclk);
        @(posedge sclk);
      end
      frame_select = 1'b1;
      // Released line must not keep the last bit
      serial_data_in = ~w[16-n];
      busy = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- bench/tb_sweep_output_control.sv
// Testbench of the sweep output controller: APB, serial port, pins.
// Assumes the serial host model drives the link pins.
`timescale 1ns/1ps
`default_nettype none
`include "sweep_output_control_map.svh"
module tb_sweep_output_control;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        sweep_abort = 1'b0;
  logic        low_power = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        frame_select;
  logic        serial_data_in;
  logic [9:0]  analog;
  logic        dac_enable;
  logic        power_down;
  logic        square;
  logic        status;
  logic [31:0] seed = 32'h0000_a30f;
  logic [31:0] v;
  logic [32:0] exp_q[$];
  logic        stat_q = 1'b0;
  int          rises = 0;
  int          miscompares = 0;
  int          check_count = 0;
  sweep_output_control uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .frame_select(frame_select),
    .serial_data_in(serial_data_in), .sweep_abort(sweep_abort), .low_power(low_power),
    .analog_current_outputs(analog), .dac_enable(dac_enable), .power_down(power_down),
    .square_wave_output(square), .sweep_status_output(status));
  serial_host_model host (.sclk(sclk), .frame_select(frame_select),
    .serial_data_in(serial_data_in));
  initial begin
    #0.7;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; the answer is judged by the monitor below
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] ctl, input int n);
    rises = 0;
    apb(`OFS_CONTROL, 1'b1, ctl, 33'h0);
    repeat (80) @(posedge pclk);
    #1;
    check("status pulses", 33'(n), 33'(rises));
    check("square pin", 33'(ctl[8] & ~analog[9]), 33'(square));
    @(posedge pclk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      check("apb answer", exp_q.size() > 0 ? exp_q.pop_front() : '1, {pslverr, prdata});
    end
    if (status === 1'b1 && stat_q !== 1'b1) begin
      rises++;
    end
    stat_q = status;
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check("reset level", 33'(`MIDSCALE), 33'(analog));
    v = rnd();
    apb(`OFS_START_FREQ, 1'b1, v, 33'h0);
    apb(`OFS_START_FREQ, 1'b0, 32'h0, {1'b0, v & `MASK_START_FREQ});
    apb(`OFS_INTERVAL, 1'b0, 32'h0, {1'b0, `RST_INTERVAL});
    apb(`OFS_STATUS, 1'b1, 32'hffff_ffff, 33'h0);
    apb(12'h018, 1'b0, 32'h0, 33'h1_0000_0000);
    $display("apb test done");
    for (int m = 0; m < 3; m++) begin
      v = rnd();
      host.send({8'h03, v[7:0]}, 16, m);
      repeat (10) @(posedge pclk);
      apb(`OFS_NUM_INCR, 1'b0, 32'h0, {25'h0, v[7:0]});
    end
    host.send(16'h03a5, 8, 0);
    repeat (10) @(posedge pclk);
    apb(`OFS_NUM_INCR, 1'b0, 32'h0, {25'h0, v[7:0]});
    $display("serial test done");
    apb(`OFS_INTERVAL, 1'b1, 32'h0000_000a, 33'h0);
    apb(`OFS_NUM_INCR, 1'b1, 32'h0000_0003, 33'h0);
    apb(`OFS_DELTA_FREQ, 1'b1, 32'h0001_0000, 33'h0);
    apb(`OFS_START_FREQ, 1'b1, 32'h0008_0000, 33'h0);
    run(32'h0000_0505, 3);
    apb(`OFS_STATUS, 1'b0, 32'h0, 33'h0_0000_4003);
    run(32'h0000_050d, 1);
    sweep_abort <= 1'b1;
    repeat (8) @(posedge pclk);
    #1;
    check("abort level", 33'(`MIDSCALE), 33'(analog));
    check("status off", 33'h0, 33'(status));
    @(posedge pclk);
    sweep_abort <= 1'b0;
    run(32'h0000_0401, 0);
    $display("sweep test done");
    apb(`OFS_CONTROL, 1'b1, 32'h0000_0605, 33'h0);
    repeat (12) @(posedge pclk);
    low_power <= 1'b1;
    repeat (6) @(posedge pclk);
    #1;
    v = 32'(analog);
    check("standby", 33'h2, {31'h0, power_down, dac_enable});
    repeat (20) @(posedge pclk);
    #1;
    check("frozen", {1'b0, v}, 33'(analog));
    @(posedge pclk);
    low_power <= 1'b0;
    // Recovery reset lands between status pulses, not inside one
    repeat (12) @(posedge pclk);
    #1;
    check("awake", 33'h2, {31'h0, dac_enable, power_down});
    apb(`OFS_CONTROL, 1'b1, 32'h0000_0002, 33'h0);
    repeat (4) @(posedge pclk);
    #1;
    check("reset after standby", 33'(`MIDSCALE), 33'(analog));
    $display("standby test done");
    end_sim();
  end
endmodule
`default_nettype wire
